// file: rtl/wot_pkg.sv
/*
  constants and types for the wait one-shot pwm timer.
  assumes a 16-bit register port with a 4-bit word address.
*/
`default_nettype none
package wot_pkg;
  // ----------------------------------------------------------------
  // register word addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE   = 4'h0; // timer_mode_reg
  localparam logic [3:0] ADDR_CTRL1  = 4'h1; // control_reg_one
  localparam logic [3:0] ADDR_CTRL2  = 4'h2; // control_reg_two
  localparam logic [3:0] ADDR_COUNT  = 4'h3; // counter_value
  localparam logic [3:0] ADDR_PERIOD = 4'h4; // period_compare
  localparam logic [3:0] ADDR_END    = 4'h5; // end_compare
  localparam logic [3:0] ADDR_START  = 4'h6; // start_compare
  localparam logic [3:0] ADDR_FLAGS  = 4'h7; // event_flag_reg, read only
  localparam logic [3:0] ADDR_FCLR   = 4'h8; // flag clear, write only
  localparam logic [3:0] ADDR_IEN    = 4'h9; // interrupt enable

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RUN_BIT    = 0; // count_run in timer_mode_reg
  localparam int POL_BIT    = 1; // output_polarity in control_reg_one
  localparam int SRC_LSB    = 4; // count_source_select, 3 bits
  localparam int CLR_BIT    = 7; // clear_on_period_match
  localparam int STOP_BIT   = 0; // stop_on_period_match in control_reg_two
  localparam int TRIG_LSB   = 3; // trigger_edge_select, 2 bits
  localparam int FLG_PERIOD = 0;
  localparam int FLG_END    = 1;
  localparam int FLG_START  = 2;
  localparam int FLG_OVF    = 3;

  // ----------------------------------------------------------------
  // count sources and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_DIV1  = 3'h0;
  localparam logic [2:0] SRC_DIV2  = 3'h1;
  localparam logic [2:0] SRC_DIV4  = 3'h2;
  localparam logic [2:0] SRC_DIV8  = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT   = 3'h5;
  localparam logic [2:0] SRC_OSC   = 3'h6;
  localparam logic [15:0] RST_CMP   = 16'hffff;
  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_ONE   = 16'h0001;

  typedef struct packed {
    logic       polarity;
    logic [2:0] source;
    logic       clearOnMatch;
    logic       stopOnMatch;
    logic [1:0] trigEdge;
  } wot_cfg_t;

  localparam wot_cfg_t CFG_RST = '{1'b0, 3'h0, 1'b0, 1'b0, 2'h0};
endpackage
`default_nettype wire

// file: rtl/wot_timer.sv
/*
  wait one-shot / periodic pwm timer: counter, three compares, one pulse
  output, register port, sticky event flags with interrupt.
  assumes count clock, fast oscillator and trigger arrive asynchronously
  and are much slower than core_clk.
*/
// How it works
// - counter write meeting the automatic clear is dropped; zero wins.
// - counter write lands one cycle late; back-to-back read sees old value.
// - a flag clear lands one cycle late; a back-to-back read sees old flags.
// - with clear enabled the period is period compare plus one ticks.
// - output is active from start match until end match.
// - with clear enabled the counter goes to zero on period match.
// - polarity zero idles low and pulses high; one inverts all levels.
// - stop on match halts count, idles output, keeps or zeroes counter.
// - source is base divided 1,2,4,8,32, external edge or fast oscillator.
// - with a trigger edge selected, counting starts on that edge while idle.
`timescale 1ns/1ps
`default_nettype none
module wot_timer
  import wot_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic      [15:0] rdata,
  input  wire logic        extCountClk,
  input  wire logic        fastOscIn,
  input  wire logic        extTrigPin,
  output logic             pulseOut,
  output logic             irq
);
  // ----------------------------------------------------------------
  // pin synchronisers: 3 flops, change taken when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] pinIn;
  logic [2:0] sync1Q, sync2Q, sync3Q, pinQ;
  logic [2:0] pinD, pinRise, pinFall;
  assign pinIn = {extTrigPin, fastOscIn, extCountClk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gSync
      assign pinD[gi] = (sync2Q[gi] == sync3Q[gi]) ? sync3Q[gi] : pinQ[gi];
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          sync1Q[gi] <= 1'b0;
          sync2Q[gi] <= 1'b0;
          sync3Q[gi] <= 1'b0;
          pinQ[gi]   <= 1'b0;
        end else begin
          sync1Q[gi] <= pinIn[gi];
          sync2Q[gi] <= sync1Q[gi];
          sync3Q[gi] <= sync2Q[gi];
          pinQ[gi]   <= pinD[gi];
        end
      end
    end
  endgenerate
  assign pinRise = pinD & ~pinQ;
  assign pinFall = ~pinD & pinQ;

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  wot_cfg_t    cfgQ, cfgD;
  logic        runQ, runD, countingQ, countingD, activeQ, activeD;
  logic [15:0] cntQ, cntD, periodQ, endQ, startQ;
  logic [3:0]  flagQ, flagD, ienQ, evtSet, fclrMaskQ;
  logic        fclrPendQ, cntPendQ;
  logic [15:0] cntPendValQ;
  logic [4:0]  preQ;
  logic        srcTick, tick, trigEdgeHit;
  logic        matchPeriod, matchEnd, matchStart, stopHit;
  logic        wrMode, wrCtrl1, wrCtrl2, wrCount, wrFclr;
  logic [15:0] rdMux;

  assign wrMode  = wrStb && (addr == ADDR_MODE);
  assign wrCtrl1 = wrStb && (addr == ADDR_CTRL1);
  assign wrCtrl2 = wrStb && (addr == ADDR_CTRL2);
  assign wrCount = wrStb && (addr == ADDR_COUNT);
  assign wrFclr  = wrStb && (addr == ADDR_FCLR);

  // ----------------------------------------------------------------
  // count source; the reserved code gives no tick at all
  // ----------------------------------------------------------------
  assign srcTick =
      (cfgQ.source == SRC_DIV1)  ? 1'b1 :
      (cfgQ.source == SRC_DIV2)  ? preQ[0] :
      (cfgQ.source == SRC_DIV4)  ? (&preQ[1:0]) :
      (cfgQ.source == SRC_DIV8)  ? (&preQ[2:0]) :
      (cfgQ.source == SRC_DIV32) ? (&preQ[4:0]) :
      (cfgQ.source == SRC_EXT)   ? pinRise[0] :
      (cfgQ.source == SRC_OSC)   ? pinRise[1] : 1'b0;
  assign tick = srcTick && countingQ;

  // ----------------------------------------------------------------
  // compares against this tick's counter value
  // ----------------------------------------------------------------
  assign matchPeriod = tick && (cntQ == periodQ);
  assign matchEnd    = tick && (cntQ == endQ);
  assign matchStart  = tick && (cntQ == startQ);
  assign stopHit     = matchPeriod && cfgQ.stopOnMatch;
  assign trigEdgeHit = (cfgQ.trigEdge[0] && pinRise[2]) ||
                       (cfgQ.trigEdge[1] && pinFall[2]);

  // hardware stop beats a same-cycle mode write; software keeps clear of it
  assign runD = stopHit ? 1'b0 : (wrMode ? wdata[RUN_BIT] : runQ);
  assign countingD = runD && ((cfgQ.trigEdge == 2'h0) ||
                     countingQ || (trigEdgeHit && !activeQ));

  assign activeD = (!runD || stopHit) ? 1'b0 :
                   matchEnd ? 1'b0 :
                   matchStart ? 1'b1 : activeQ;

  // clear beats a pending write; write beats an increment
  assign cntD = (matchPeriod && cfgQ.clearOnMatch) ? RST_ZERO :
                cntPendQ ? cntPendValQ :
                (stopHit || !tick) ? cntQ :
                cntQ + CNT_ONE;

  assign cfgD = wrCtrl1 ? '{wdata[POL_BIT], wdata[SRC_LSB +: 3],
                            wdata[CLR_BIT], cfgQ.stopOnMatch,
                            cfgQ.trigEdge} :
                wrCtrl2 ? '{cfgQ.polarity, cfgQ.source,
                            cfgQ.clearOnMatch, wdata[STOP_BIT],
                            wdata[TRIG_LSB +: 2]} : cfgQ;

  assign evtSet = {tick && (cntQ == CNT_MAX) && !matchPeriod,
                   matchStart, matchEnd, matchPeriod};
  // a new event wins over a clear landing in the same cycle
  assign flagD = (fclrPendQ ? (flagQ & ~fclrMaskQ) : flagQ) | evtSet;

  assign rdMux =
      (addr == ADDR_MODE)   ? {15'h0, runQ} :
      (addr == ADDR_CTRL1)  ? {8'h00, cfgQ.clearOnMatch, cfgQ.source,
                               2'h0, cfgQ.polarity, 1'b0} :
      (addr == ADDR_CTRL2)  ? {11'h0, cfgQ.trigEdge, 2'h0,
                               cfgQ.stopOnMatch} :
      (addr == ADDR_COUNT)  ? cntQ :
      (addr == ADDR_PERIOD) ? periodQ :
      (addr == ADDR_END)    ? endQ :
      (addr == ADDR_START)  ? startQ :
      (addr == ADDR_FLAGS)  ? {12'h000, flagQ} :
      (addr == ADDR_IEN)    ? {12'h000, ienQ} : 16'h0000;

  assign irq = |(flagQ & ienQ);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfgQ        <= CFG_RST;
      runQ        <= 1'b0;
      countingQ   <= 1'b0;
      activeQ     <= 1'b0;
      pulseOut    <= 1'b0;
      cntQ        <= RST_ZERO;
      periodQ     <= RST_CMP;
      endQ        <= RST_CMP;
      startQ      <= RST_CMP;
      flagQ       <= 4'h0;
      ienQ        <= 4'h0;
      fclrPendQ   <= 1'b0;
      fclrMaskQ   <= 4'h0;
      cntPendQ    <= 1'b0;
      cntPendValQ <= RST_ZERO;
      preQ        <= 5'h00;
      rdata       <= 16'h0000;
    end else begin
      cfgQ        <= cfgD;
      runQ        <= runD;
      countingQ   <= countingD;
      activeQ     <= activeD;
      pulseOut    <= activeD ^ cfgQ.polarity;
      cntQ        <= cntD;
      flagQ       <= flagD;
      fclrPendQ   <= wrFclr;
      fclrMaskQ   <= wrFclr ? wdata[3:0] : 4'h0;
      cntPendQ    <= wrCount;
      cntPendValQ <= wrCount ? wdata : cntPendValQ;
      preQ        <= preQ + 5'h01;
      rdata       <= rdStb ? rdMux : 16'h0000;
      if (wrStb && (addr == ADDR_PERIOD)) begin
        periodQ <= wdata;
      end
      if (wrStb && (addr == ADDR_END)) begin
        endQ <= wdata;
      end
      if (wrStb && (addr == ADDR_START)) begin
        startQ <= wdata;
      end
      if (wrStb && (addr == ADDR_IEN)) begin
        ienQ <= wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_clear_wins: assert property (matchPeriod && cfgQ.clearOnMatch
      |=> cntQ == 16'h0000) else $error("clear did not win");
  a_write_late: assert property (wrCount && !countingQ
      |=> cntQ == $past(cntQ) ##1 cntQ == $past(wdata, 2))
      else $error("counter write timing wrong");
  a_flag_clear: assert property (fclrPendQ
      |=> (flagQ & $past(fclrMaskQ) & ~$past(evtSet)) == 4'h0)
      else $error("flag clear not applied");
  a_flag_sticky: assert property (evtSet[FLG_END]
      |=> flagQ[FLG_END]) else $error("event flag lost");
  a_idle_level: assert property (!activeQ && $stable(cfgQ.polarity)
      |-> pulseOut == cfgQ.polarity) else $error("idle level wrong");
  a_stop_match: assert property (stopHit
      |=> !countingQ && !runQ && !activeQ ##1 pulseOut == cfgQ.polarity)
      else $error("stop on match failed");
  a_trig_start: assert property (runQ && wrMode == 1'b0 &&
      cfgQ.trigEdge != 2'h0 && !countingQ && trigEdgeHit && !activeQ
      |=> countingQ) else $error("trigger did not start count");
  a_no_trig_hold: assert property (cfgQ.trigEdge != 2'h0 &&
      !countingQ && !trigEdgeHit |=> !countingQ)
      else $error("count started without trigger");
  a_step_one: assert property (tick && !cntPendQ && !matchPeriod
      |=> cntQ == $past(cntQ) + 16'h0001) else $error("bad increment");
  a_end_drop: assert property (matchEnd
      |=> !activeQ) else $error("end match did not end pulse");
  a_src_resvd: assert property (cfgQ.source == 3'h7 && !cntPendQ
      |=> cntQ == $past(cntQ)) else $error("reserved source ticked");
endmodule
`default_nettype wire

// file: sim/wot_timer_tb_top.sv
/*
  self-checking bench for the wot timer: pwm timing, stop on match,
  flags and irq, register latency, count sources and trigger edges.
  assumes the timer alone sits on the register port, clock 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module wot_timer_tb_top
  import wot_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk    = 1'b0;
  logic        nrst        = 1'b0;
  logic [3:0]  addr        = 4'h0;
  logic [15:0] wdata       = 16'h0000;
  logic        wrStb       = 1'b0;
  logic        rdStb       = 1'b0;
  logic [15:0] rdata;
  logic        extCountClk = 1'b0;
  logic        fastOscIn   = 1'b0;
  logic        extTrigPin  = 1'b0;
  logic        pulseOut;
  logic        irq;
  logic [15:0] d;
  logic        pl;
  int          bad_count   = 0;
  int          checked     = 0;
  int          seedTmp, p, s, e, n, w, r, v;

  always #5 core_clk = ~core_clk;

  wot_timer dut (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .addr       (addr),
    .wdata      (wdata),
    .wrStb      (wrStb),
    .rdStb      (rdStb),
    .rdata      (rdata),
    .extCountClk(extCountClk),
    .fastOscIn  (fastOscIn),
    .extTrigPin (extTrigPin),
    .pulseOut   (pulseOut),
    .irq        (irq)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes are set on every call so back-to-back calls never lower one
  task automatic wr(input logic [3:0] a, input logic [15:0] dd);
    addr  <= a;
    wdata <= dd;
    wrStb <= 1'b1;
    rdStb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic idle(input int k);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    repeat (k) @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    addr  <= a;
    rdStb <= 1'b1;
    wrStb <= 1'b0;
    @(posedge core_clk);
    rdStb <= 1'b0;
    @(posedge core_clk);
    q = rdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd(a, q);
    chk(q, exp);
  endtask

  task automatic waitLvl(input logic lvl, output int k);
    k = 0;
    while (pulseOut !== lvl) begin
      @(posedge core_clk);
      k++;
      if (k > 4000) begin
        bad_count++;
        $display("ERROR %0t pulse output stuck", $time);
        end_of_test();
      end
    end
  endtask

  // slow edges: synchronisers need several core cycles per level
  task automatic pulses(input int k);
    repeat (k) begin
      extCountClk <= 1'b1;
      fastOscIn   <= 1'b1;
      repeat (8) @(posedge core_clk);
      extCountClk <= 1'b0;
      fastOscIn   <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask

  function automatic logic [15:0] rstVal(input int i);
    return (i >= 4 && i <= 6) ? RST_CMP : RST_ZERO;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seedTmp = $urandom(22);
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      rdc(4'(i), rstVal(i));
    end
    for (int pol = 0; pol < 2; pol++) begin
      pl = 1'(pol);
      p  = 20 + $urandom_range(40);
      s  = 1 + $urandom_range(4);
      e  = s + 1 + $urandom_range(9);
      wr(ADDR_CTRL1, 16'h0080 | 16'(pol << POL_BIT));
      wr(ADDR_PERIOD, 16'(p));
      wr(ADDR_START, 16'(s));
      wr(ADDR_END, 16'(e));
      wr(ADDR_COUNT, RST_ZERO);
      idle(4);
      chk({15'h0, pulseOut}, 16'(pol));
      wr(ADDR_MODE, 16'h0001);
      idle(1);
      waitLvl(~pl, n);
      waitLvl(pl, w);
      waitLvl(~pl, r);
      chk(16'(w), 16'(e - s));
      chk(16'(w + r), 16'(p + 1));
      wr(ADDR_MODE, RST_ZERO);
      idle(3);
      chk({15'h0, pulseOut}, 16'(pol));
    end
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_CTRL1, 16'(c << CLR_BIT));
      wr(ADDR_CTRL2, 16'h0001);
      wr(ADDR_COUNT, RST_ZERO);
      wr(ADDR_FCLR, 16'h000f);
      wr(ADDR_MODE, 16'h0001);
      idle(p + 20);
      rdc(ADDR_MODE, RST_ZERO);
      rdc(ADDR_COUNT, (c == 1) ? RST_ZERO : 16'(p));
      chk({15'h0, pulseOut}, 16'h0000);
      rdc(ADDR_FLAGS, 16'h0007);
      chk({15'h0, irq}, 16'h0000);
      wr(ADDR_IEN, 16'h0001);
      idle(2);
      chk({15'h0, irq}, 16'h0001);
      wr(ADDR_FCLR, 16'h0001);
      rdc(ADDR_FLAGS, 16'h0007);
      rdc(ADDR_FLAGS, 16'h0006);
      chk({15'h0, irq}, 16'h0000);
      wr(ADDR_IEN, RST_ZERO);
    end
    v = $urandom_range(16'hfffe, 1);
    wr(ADDR_COUNT, 16'(v));
    rdc(ADDR_COUNT, RST_ZERO);
    rdc(ADDR_COUNT, 16'(v));
    wr(ADDR_CTRL2, RST_ZERO);
    // wrap past ffff must raise the overflow flag; other flags may also set
    wr(ADDR_FCLR, 16'h000f);
    wr(ADDR_COUNT, 16'hfffa);
    wr(ADDR_MODE, 16'h0001);
    idle(12);
    wr(ADDR_MODE, RST_ZERO);
    rd(ADDR_FLAGS, d);
    chk(d & 16'h0008, 16'h0008);
    for (int k = 1; k < 8; k++) begin
      wr(ADDR_CTRL1, 16'(k << SRC_LSB));
      wr(ADDR_COUNT, RST_ZERO);
      wr(ADDR_MODE, 16'h0001);
      if (k < 5) begin
        idle(256);
      end else begin
        idle(1);
        pulses(10);
        idle(10);
      end
      wr(ADDR_MODE, RST_ZERO);
      idle(2);
      rd(ADDR_COUNT, d);
      n = 256 / ((k == 4) ? 32 : (1 << k));
      if (k < 5) begin
        chk(16'(d + 16'h2 >= 16'(n) && d <= 16'(n + 3)), CNT_ONE);
      end else begin
        chk(d, (k == 7) ? RST_ZERO : 16'h000a);
      end
    end
    wr(ADDR_CTRL1, RST_ZERO);
    for (int t = 1; t < 4; t++) begin
      extTrigPin <= (t == 2);
      wr(ADDR_CTRL2, 16'(t << TRIG_LSB));
      wr(ADDR_COUNT, RST_ZERO);
      wr(ADDR_MODE, 16'h0001);
      idle(20);
      rdc(ADDR_COUNT, RST_ZERO);
      extTrigPin <= (t != 2);
      idle(20);
      wr(ADDR_MODE, RST_ZERO);
      rd(ADDR_COUNT, d);
      chk(16'(d > 16'h0004), CNT_ONE);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
